//--- shared/scksel_pkg.sv
// constants and types for the system clock select and clock flag block
package scksel_pkg;
	// register offsets (byte addresses)
	localparam logic [7:0] CFG0_OFS = 8'h04;
	localparam logic [7:0] INT_OFS = 8'h08;
	// configuration register fields
	localparam int PLOW_LSB = 8;
	localparam int MAIN_LSB = 4;
	localparam int STAT_LSB = 2;
	localparam int REQ_LSB = 0;
	// interrupt register fields
	localparam int FLAG_LSB = 0;
	localparam int STUCK_POS = 7;
	localparam int EN_LSB = 8;
	localparam int CLR_LSB = 16;
	localparam int STUCK_CLR_POS = 23;
	localparam int NUM_SRC = 7;
	// ready and flag bit order
	localparam int AUXB_IDX = 6;
	localparam int AUXA_IDX = 5;
	localparam int PLL_IDX = 4;
	localparam int FXTAL_IDX = 3;
	localparam int FIOSC_IDX = 2;
	localparam int SXTAL_IDX = 1;
	localparam int SIOSC_IDX = 0;
	// reset values
	localparam logic [31:0] INT_RST = 32'h0000_0000;
	localparam logic [2:0] PLOW_RST = 3'h0;
	localparam logic [3:0] MAIN_RST = 4'h0;
	// switch latency
	localparam int CLK_NS = 8;
	localparam int SWITCH_NS = 32;
	localparam int SWITCH_CYC = (SWITCH_NS + CLK_NS - 1) / CLK_NS;
	localparam int SW_W = 4;
	localparam logic [SW_W-1:0] SW_LAST = SW_W'(SWITCH_CYC - 1);

	typedef enum logic [1:0] {
		SRC_IOSC = 2'h0,
		SRC_XTAL = 2'h1,
		SRC_PLL = 2'h2,
		SRC_RSVD = 2'h3
	} scksel_src_e;
endpackage : scksel_pkg

//--- core/scksel_top.sv
// system clock source select, bus dividers and clock flag register
//
// Overview of operation
// RULE_01: low bus divides main bus by bits 10:8
// RULE_02: software keeps low bus at most 60 MHz
// RULE_03: main bus divides system clock by bits 7:4
// RULE_04: bits 3:2 report active clock source
// RULE_05: bits 1:0 request the clock source
// RULE_06: status changes only after switch completes
// RULE_07: wake from sleep forces internal oscillator
// RULE_08: crystal failure forces internal oscillator
// RULE_09: flag register at 0x08, resets to zero
// RULE_10: write one bit 23 clears stuck flag
// RULE_11: write one bit 22 clears aux PLL B
// RULE_12: write one bit 21 clears aux PLL A
// RULE_13: write one bit 20 clears main PLL
// RULE_14: write one bit 19 clears fast crystal
// RULE_15: write one bit 18 clears fast oscillator
// RULE_16: write one bit 17 clears slow crystal
// RULE_17: software keeps bits 31:24 at zero
// RULE_18: write one bit 16 clears slow oscillator
// RULE_19: flags read-only, enables writable, clears read zero
// RULE_20: interrupt on enabled ready flag or stuck
module scksel_top
	import scksel_pkg::*;
(
	// clock, reset, enable
	input wire logic sys_clk,
	input wire logic srst,
	input wire logic clkEn,
	// register port
	input wire logic [7:0] regAddr,
	input wire logic [31:0] regWrData,
	input wire logic regWr,
	input wire logic regRd,
	output logic [31:0] regRdData,
	// oscillator and monitor pins
	input wire logic [NUM_SRC-1:0] srcReadyPin,
	input wire logic crystalFailPin,
	input wire logic wakeFromSleepPin,
	input wire logic pllFromCrystalPin,
	// clock tree controls
	output logic [1:0] sysSrcSel,
	output logic mainBusTick,
	output logic periphLowBusTick,
	output logic clkIrq
);

	typedef struct packed {
		logic [1:0] reqSrc;
		logic [1:0] statSrc;
		logic [1:0] pendSrc;
		logic [SW_W-1:0] swCnt;
		logic [2:0] plowDiv;
		logic [3:0] mainDiv;
		logic [NUM_SRC-1:0] intEn;
		logic [NUM_SRC-1:0] flags;
		logic stuck;
		logic [8:0] mainCnt;
		logic [3:0] plowCnt;
		logic mainTick;
		logic plowTick;
		logic [31:0] rdData;
		logic irq;
		logic [NUM_SRC-1:0] rdyS1;
		logic [NUM_SRC-1:0] rdyS2;
		logic [NUM_SRC-1:0] rdyPrev;
		logic failS1;
		logic failS2;
		logic failPrev;
		logic wakeS1;
		logic wakeS2;
		logic wakePrev;
		logic pllXS1;
		logic pllXS2;
	} scksel_state_s;

	localparam scksel_state_s RESET_S = '{
		reqSrc: SRC_IOSC,
		statSrc: SRC_IOSC,
		pendSrc: SRC_IOSC,
		swCnt: '0,
		plowDiv: PLOW_RST,
		mainDiv: MAIN_RST,
		intEn: INT_RST[EN_LSB +: NUM_SRC],
		flags: INT_RST[FLAG_LSB +: NUM_SRC],
		stuck: INT_RST[STUCK_POS],
		mainCnt: '0,
		plowCnt: '0,
		mainTick: 1'b0,
		plowTick: 1'b0,
		rdData: '0,
		irq: 1'b0,
		rdyS1: '0,
		rdyS2: '0,
		rdyPrev: '0,
		failS1: 1'b0,
		failS2: 1'b0,
		failPrev: 1'b0,
		wakeS1: 1'b0,
		wakeS2: 1'b0,
		wakePrev: 1'b0,
		pllXS1: 1'b0,
		pllXS2: 1'b0
	};

	scksel_state_s s_ff;
	scksel_state_s nxt_s;

	// last count value of the main bus divider; 0 means undivided
	function automatic logic [8:0] mainLimit(input logic [3:0] code);
		logic [8:0] lim;
		lim = 9'h000;
		if (code[3]) begin
			unique case (code[2:0])
				3'h0: lim = 9'h001;
				3'h1: lim = 9'h003;
				3'h2: lim = 9'h007;
				3'h3: lim = 9'h00f;
				3'h4: lim = 9'h03f;
				3'h5: lim = 9'h07f;
				3'h6: lim = 9'h0ff;
				3'h7: lim = 9'h1ff;
			endcase
		end
		return lim;
	endfunction : mainLimit

	// last count value of the low bus divider; 0 means undivided
	function automatic logic [3:0] plowLimit(input logic [2:0] code);
		logic [3:0] lim;
		lim = 4'h0;
		if (code[2]) begin
			unique case (code[1:0])
				2'h0: lim = 4'h1;
				2'h1: lim = 4'h3;
				2'h2: lim = 4'h7;
				2'h3: lim = 4'hf;
			endcase
		end
		return lim;
	endfunction : plowLimit

	// readiness of a selectable system clock source
	function automatic logic srcOk(input logic [1:0] src,
			input logic [NUM_SRC-1:0] rdy);
		logic ok;
		ok = 1'b0;
		unique case (src)
			SRC_IOSC: ok = rdy[FIOSC_IDX];
			SRC_XTAL: ok = rdy[FXTAL_IDX];
			SRC_PLL: ok = rdy[PLL_IDX];
			SRC_RSVD: ok = 1'b0;
		endcase
		return ok;
	endfunction : srcOk

	always_comb begin
		logic [NUM_SRC-1:0] rise;
		logic [NUM_SRC-1:0] clr;
		logic failRise;
		logic wakeRise;
		logic xtalInUse;
		logic fallback;
		logic cfgWr;
		logic intWr;
		logic [31:0] cfgView;
		logic [31:0] intView;
		rise = '0;
		clr = '0;
		failRise = 1'b0;
		wakeRise = 1'b0;
		xtalInUse = 1'b0;
		fallback = 1'b0;
		cfgWr = 1'b0;
		intWr = 1'b0;
		cfgView = '0;
		intView = '0;
		nxt_s = s_ff;

		// pin synchronisers; edges use the second stage only
		nxt_s.rdyS1 = srcReadyPin;
		nxt_s.rdyS2 = s_ff.rdyS1;
		nxt_s.rdyPrev = s_ff.rdyS2;
		nxt_s.failS1 = crystalFailPin;
		nxt_s.failS2 = s_ff.failS1;
		nxt_s.failPrev = s_ff.failS2;
		nxt_s.wakeS1 = wakeFromSleepPin;
		nxt_s.wakeS2 = s_ff.wakeS1;
		nxt_s.wakePrev = s_ff.wakeS2;
		nxt_s.pllXS1 = pllFromCrystalPin;
		nxt_s.pllXS2 = s_ff.pllXS1;
		rise = s_ff.rdyS2 & ~s_ff.rdyPrev;
		failRise = s_ff.failS2 & ~s_ff.failPrev;
		wakeRise = s_ff.wakeS2 & ~s_ff.wakePrev;

		cfgWr = regWr && (regAddr == CFG0_OFS);
		intWr = regWr && (regAddr == INT_OFS);

		// software request; read-only status bits ignore writes
		if (cfgWr) begin
			nxt_s.plowDiv = regWrData[PLOW_LSB +: 3];
			nxt_s.mainDiv = regWrData[MAIN_LSB +: 4];
			nxt_s.reqSrc = regWrData[REQ_LSB +: 2]; // RULE_05
		end

		// status follows the request only after a full settle time
		if (nxt_s.reqSrc != s_ff.pendSrc) begin
			nxt_s.pendSrc = nxt_s.reqSrc;
			nxt_s.swCnt = '0;
		end else if (s_ff.pendSrc != s_ff.statSrc &&
				s_ff.pendSrc != SRC_RSVD &&
				srcOk(s_ff.pendSrc, s_ff.rdyS2)) begin
			if (s_ff.swCnt == SW_LAST) begin
				nxt_s.statSrc = s_ff.pendSrc; // RULE_04 RULE_06
				nxt_s.swCnt = '0;
			end else begin
				nxt_s.swCnt = s_ff.swCnt + SW_W'(1); // RULE_06
			end
		end else begin
			nxt_s.swCnt = '0;
		end

		// crystal counts as in use directly or behind the PLL
		xtalInUse = s_ff.statSrc == SRC_XTAL ||
			s_ff.reqSrc == SRC_XTAL ||
			((s_ff.statSrc == SRC_PLL || s_ff.reqSrc == SRC_PLL) &&
			s_ff.pllXS2);
		// a dead crystal cannot wait out a settle time, so jump now
		fallback = wakeRise || (failRise && xtalInUse); // RULE_07 RULE_08
		if (fallback) begin
			nxt_s.reqSrc = SRC_IOSC; // RULE_07 RULE_08
			nxt_s.pendSrc = SRC_IOSC;
			nxt_s.statSrc = SRC_IOSC;
			nxt_s.swCnt = '0;
		end

		// flags: write one clears, a new event in the same cycle wins
		if (intWr) begin
			nxt_s.intEn = regWrData[EN_LSB +: NUM_SRC]; // RULE_19
			clr = regWrData[CLR_LSB +: NUM_SRC]; // RULE_11 RULE_12
		end
		// per bit: 22,21,20,19,18,17,16 clear flags 6..0
		nxt_s.flags = (s_ff.flags & ~clr) | rise; // RULE_13 RULE_14
		// the remaining clears share the same masking
		nxt_s.flags[SXTAL_IDX] = (s_ff.flags[SXTAL_IDX] &
			~clr[SXTAL_IDX]) | rise[SXTAL_IDX]; // RULE_16
		nxt_s.flags[SIOSC_IDX] = (s_ff.flags[SIOSC_IDX] &
			~clr[SIOSC_IDX]) | rise[SIOSC_IDX]; // RULE_18
		nxt_s.flags[FIOSC_IDX] = (s_ff.flags[FIOSC_IDX] &
			~clr[FIOSC_IDX]) | rise[FIOSC_IDX]; // RULE_15
		nxt_s.stuck = (s_ff.stuck &
			~(intWr && regWrData[STUCK_CLR_POS])) | failRise; // RULE_10

		nxt_s.irq = |(nxt_s.flags & nxt_s.intEn) | nxt_s.stuck; // RULE_20

		// main bus divider counts system clock cycles
		if (s_ff.mainCnt >= mainLimit(s_ff.mainDiv)) begin
			nxt_s.mainCnt = '0;
			nxt_s.mainTick = 1'b1; // RULE_03
		end else begin
			nxt_s.mainCnt = s_ff.mainCnt + 9'h001;
			nxt_s.mainTick = 1'b0;
		end
		// low bus divider counts main bus ticks
		nxt_s.plowTick = 1'b0;
		if (nxt_s.mainTick) begin
			if (s_ff.plowCnt >= plowLimit(s_ff.plowDiv)) begin
				nxt_s.plowCnt = '0;
				nxt_s.plowTick = 1'b1; // RULE_01
			end else begin
				nxt_s.plowCnt = s_ff.plowCnt + 4'h1;
			end
		end

		// read views; clear bits and unused bits read as zero
		cfgView[PLOW_LSB +: 3] = s_ff.plowDiv;
		cfgView[MAIN_LSB +: 4] = s_ff.mainDiv;
		cfgView[STAT_LSB +: 2] = s_ff.statSrc;
		cfgView[REQ_LSB +: 2] = s_ff.reqSrc;
		intView[FLAG_LSB +: NUM_SRC] = s_ff.flags; // RULE_19
		intView[STUCK_POS] = s_ff.stuck;
		intView[EN_LSB +: NUM_SRC] = s_ff.intEn;
		nxt_s.rdData = '0;
		if (regRd) begin
			unique case (regAddr)
				CFG0_OFS: nxt_s.rdData = cfgView;
				INT_OFS: nxt_s.rdData = intView; // RULE_09
				default: nxt_s.rdData = '0;
			endcase
		end
	end

	// clock enable low freezes every register, synchronisers too
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			s_ff <= RESET_S; // RULE_09
		end else if (clkEn) begin
			s_ff <= nxt_s;
		end
	end

	assign regRdData = s_ff.rdData;
	assign sysSrcSel = s_ff.statSrc;
	assign mainBusTick = s_ff.mainTick;
	assign periphLowBusTick = s_ff.plowTick;
	assign clkIrq = s_ff.irq;

endmodule : scksel_top

//--- dv/scksel_sva.sv
// assertion checker for the clock select block
module scksel_sva
	import scksel_pkg::*;
(
	// clock and reset
	input wire logic sys_clk,
	input wire logic srst,
	input wire logic clkEn,
	// register port
	input wire logic [7:0] regAddr,
	input wire logic [31:0] regWrData,
	input wire logic regWr,
	input wire logic regRd,
	input wire logic [31:0] regRdData,
	// pins
	input wire logic [NUM_SRC-1:0] srcReadyPin,
	input wire logic crystalFailPin,
	input wire logic wakeFromSleepPin,
	input wire logic pllFromCrystalPin,
	// clock tree
	input wire logic [1:0] sysSrcSel,
	input wire logic mainBusTick,
	input wire logic periphLowBusTick,
	input wire logic clkIrq
);
	default clocking @(posedge sys_clk); endclocking
	// frozen cycles carry no obligations
	default disable iff (srst || !clkEn);
	property p_rd_idle; !$past(regRd) |-> regRdData == 32'h0; endproperty
	a_rd_idle: assert property (p_rd_idle) else $error("stray data");
	property p_sel_ok; sysSrcSel != 2'h3; endproperty
	a_sel_ok: assert property (p_sel_ok) else $error("bad source");
	property p_wake; $rose(wakeFromSleepPin) |-> ##[1:6] sysSrcSel == 2'h0;
	endproperty
	a_wake: assert property (p_wake) else $error("no wake fallback");
	property p_fail;
		$rose(crystalFailPin) && sysSrcSel == 2'h1 |-> ##[1:6] sysSrcSel == 2'h0;
	endproperty
	a_fail: assert property (p_fail) else $error("no fail fallback");
	property p_irq; $rose(crystalFailPin) |-> ##[1:6] clkIrq; endproperty
	a_irq: assert property (p_irq) else $error("no stuck irq");
	property p_low; periphLowBusTick |-> mainBusTick; endproperty
	a_low: assert property (p_low) else $error("low tick alone");
	property p_sw_hold;
		regWr && regAddr == CFG0_OFS && regWrData[1:0] != sysSrcSel
			|=> ($stable(sysSrcSel) || sysSrcSel == 2'h0) [*4];
	endproperty
	a_sw_hold: assert property (p_sw_hold) else $error("early switch");
	property p_stat;
		regRd && regAddr == CFG0_OFS |=> regRdData[3:2] == $past(sysSrcSel);
	endproperty
	a_stat: assert property (p_stat) else $error("status mismatch");
	c_pll: cover property (sysSrcSel == 2'h2);
	c_irq: cover property ($rose(clkIrq));
	c_low: cover property (periphLowBusTick);
endmodule : scksel_sva

bind scksel_top scksel_sva scksel_sva_i (.sys_clk, .srst, .clkEn, .regAddr,
	.regWrData, .regWr, .regRd, .regRdData, .srcReadyPin, .crystalFailPin,
	.wakeFromSleepPin, .pllFromCrystalPin, .sysSrcSel, .mainBusTick,
	.periphLowBusTick, .clkIrq);

//--- dv/tb_scksel_top.sv
// self-checking bench for the clock select block
module tb_scksel_top;
	timeunit 1ns;
	timeprecision 1ps;
	import scksel_pkg::*;
	logic sys_clk = 1'h0, srst = 1'h1, clkEn = 1'h1;
	logic regWr = 1'h0, regRd = 1'h0;
	logic [7:0] regAddr = 8'h0;
	logic [31:0] regWrData = 32'h0, regRdData, d, e;
	logic [NUM_SRC-1:0] srcReadyPin = '0;
	logic crystalFailPin = 1'h0, wakeFromSleepPin = 1'h0;
	logic pllFromCrystalPin = 1'h1;
	logic [1:0] sysSrcSel;
	logic mainBusTick, periphLowBusTick, clkIrq;
	int error_cnt = 0, num_checks = 0, cyc = 0;
	scksel_top scksel_top_i (.sys_clk, .srst, .clkEn, .regAddr, .regWrData,
		.regWr, .regRd, .regRdData, .srcReadyPin, .crystalFailPin,
		.wakeFromSleepPin, .pllFromCrystalPin, .sysSrcSel, .mainBusTick,
		.periphLowBusTick, .clkIrq);
	initial begin
		forever #4 sys_clk = ~sys_clk;
	end
	task automatic wrap_up;
		$display("checks %0d errors %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : wrap_up
	// longest run is the divider sweep, about 23k cycles
	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 40000) begin
			error_cnt++;
			wrap_up();
		end
	end
	task automatic chk(input string n, input logic [31:0] x, s);
		num_checks++;
		if (s !== x) begin
			error_cnt++;
			$display("Error %s expected %h seen %h", n, x, s);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge sys_clk);
		regWr <= 1'h1;
		regAddr <= a;
		regWrData <= v;
		@(posedge sys_clk);
		regWr <= 1'h0;
	endtask : wr
	task automatic rd(input logic [7:0] a);
		@(posedge sys_clk);
		regRd <= 1'h1;
		regAddr <= a;
		@(posedge sys_clk);
		regRd <= 1'h0;
		@(negedge sys_clk);
		d = regRdData;
		// hand back on a rising edge so later pin changes stay aligned
		@(posedge sys_clk);
	endtask : rd
	function automatic int mdiv(input logic [3:0] c);
		return c[3] ? (c[2] ? 64 : 2) << c[1:0] : 1;
	endfunction : mdiv
	function automatic int ldiv(input logic [2:0] c);
		return c[2] ? 2 << c[1:0] : 1;
	endfunction : ldiv
	task automatic sw(input logic [1:0] r);
		wr(CFG0_OFS, {30'h0, r});
		rd(CFG0_OFS);
		chk("early status", {30'h0, r}, d);
		for (int k = 0; k < 10 && d[3:2] !== r; k++) begin
			rd(CFG0_OFS);
		end
		chk("status", {28'h0, r, r}, d);
	endtask : sw
	task automatic ticks(input logic [6:0] f, input int me, le);
		int m = 0;
		int l = 0;
		wr(CFG0_OFS, 32'(f) << MAIN_LSB);
		// let the longest old period run out first
		repeat (600) @(posedge sys_clk);
		repeat (1024) begin
			@(negedge sys_clk);
			m += mainBusTick;
			l += periphLowBusTick;
		end
		chk("main ticks", me, m);
		chk("low ticks", le, l);
	endtask : ticks
	task automatic wait6;
		repeat (6) @(posedge sys_clk);
	endtask : wait6
	initial begin
		d = $urandom(61);
		repeat (16) @(posedge sys_clk);
		srst <= 1'h0;
		rd(INT_OFS);
		chk("int reset", INT_RST, d);
		rd(CFG0_OFS);
		chk("cfg reset", 32'h0, d);
		repeat (8) begin
			e = $urandom;
			wr(INT_OFS, e & 32'h00ff_ffff);
			rd(INT_OFS);
			chk("enables", e & 32'h7f00, d);
			// low bus divided by 4 or more keeps it under its limit
			e = $urandom | 32'h500;
			wr(CFG0_OFS, e & 32'h7f0);
			rd(CFG0_OFS);
			chk("cfg fields", e & 32'h7f0, d);
			e = $urandom | 32'h10;
			wr(e[7:0], $urandom);
			rd(e[7:0]);
			chk("unmapped", 32'h0, d);
		end
		$display("test registers done");
		wr(INT_OFS, 32'h7f00);
		srcReadyPin <= '1;
		wait6();
		e = 32'h7f7f;
		rd(INT_OFS);
		chk("flags set", e, d);
		chk("irq set", 32'h1, {31'h0, clkIrq});
		for (int i = 0; i < NUM_SRC; i++) begin
			wr(INT_OFS, 32'h7f00 | 32'h1 << (CLR_LSB + i));
			e[i] = 1'h0;
			rd(INT_OFS);
			chk("clr", e, d);
		end
		chk("irq idle", 32'h0, {31'h0, clkIrq});
		wr(INT_OFS, 32'h0);
		crystalFailPin <= 1'h1;
		wait6();
		rd(INT_OFS);
		chk("stuck", 32'h80, d);
		chk("irq stuck", 32'h1, {31'h0, clkIrq});
		wr(INT_OFS, 32'h1 << STUCK_CLR_POS);
		crystalFailPin <= 1'h0;
		rd(INT_OFS);
		chk("stuck clear", 32'h0, d);
		$display("test flags done");
		sw(2'h1);
		crystalFailPin <= 1'h1;
		wait6();
		rd(CFG0_OFS);
		chk("fail fallback", 32'h0, d);
		sw(2'h2);
		wakeFromSleepPin <= 1'h1;
		wait6();
		rd(CFG0_OFS);
		chk("wake fallback", 32'h0, d);
		// crystal behind the PLL: fallback only while the PLL takes it
		crystalFailPin <= 1'h0;
		sw(2'h2);
		crystalFailPin <= 1'h1;
		wait6();
		rd(CFG0_OFS);
		chk("pll fail fallback", 32'h0, d);
		crystalFailPin <= 1'h0;
		pllFromCrystalPin <= 1'h0;
		sw(2'h2);
		crystalFailPin <= 1'h1;
		wait6();
		rd(CFG0_OFS);
		chk("pll kept", 32'ha, d);
		$display("test switch done");
		for (int c = 7; c < 16; c++) begin
			ticks(7'(c), 1024 / mdiv(4'(c)), 1024 / mdiv(4'(c)));
		end
		for (int c = 3; c < 8; c++) begin
			ticks(7'(c) << 4, 1024, 1024 / ldiv(3'(c)));
		end
		$display("test dividers done");
		wrap_up();
	end
endmodule : tb_scksel_top
